/* File: hdl/cfg_loader_pkg.sv */
// Constants and types for the configuration loader
package cfg_loader_pkg;
    localparam logic [7:0] SIG_LOW_ADDR     = 8'h00;
    localparam logic [7:0] SIG_HIGH_ADDR    = 8'h01;
    localparam logic [7:0] POWER_MGMT_ADDR  = 8'h02;
    localparam logic [7:0] RESERVED_ADDR    = 8'h03;
    localparam logic [7:0] VENDOR_CMD_ADDR  = 8'h04;
    localparam logic [7:0] OPTION_ADDR      = 8'h05;
    localparam logic [7:0] SIG_LOW_VALUE    = 8'h53;
    localparam logic [7:0] SIG_HIGH_VALUE   = 8'h4b;
    localparam logic [7:0] POWER_MGMT_RESET = 8'h00;
    localparam logic [7:0] VENDOR_CMD_RESET = 8'h24;
    localparam logic [7:0] OPTION_RESET     = 8'h07;
    localparam int         OPT_MODE_PAGE    = 5;
    localparam int         OPT_POLL         = 4;
    localparam int         OPT_BUSY_DELAY   = 3;
    localparam int         OPT_SHORT_PKT    = 2;
    localparam int         OPT_SOFT_RESET   = 1;
    localparam int         OPT_SKIP_PIN     = 0;
    localparam logic [6:0] DEV_ADDR_A       = 7'h52;
    localparam logic [6:0] DEV_ADDR_B       = 7'h54;
    localparam int         CFG_BYTES        = 6;
    localparam int         CLK_HZ           = 40_000_000;
    localparam int         BUSY_DELAY_MS    = 120;
    localparam int         BUSY_DELAY_CYC   = (CLK_HZ / 1000) * BUSY_DELAY_MS;
    localparam int         I2C_KHZ          = 100;
    localparam int         I2C_QUARTER_CYC  = CLK_HZ / (I2C_KHZ * 1000 * 4);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DONE
    } load_state_t;
endpackage

/* File: hdl/eeprom_config_loader.sv */
// Configuration loader reading six bytes from the serial EEPROM
module eeprom_config_loader #(
    parameter int BUSY_DELAY_CYCLES = cfg_loader_pkg::BUSY_DELAY_CYC,
    parameter int QUARTER_CYCLES    = cfg_loader_pkg::I2C_QUARTER_CYC
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Load control and address strap
    input  wire logic       load_start_in,
    input  wire logic       alt_addr_in,
    // Serial EEPROM pins
    input  wire logic       scl_pin_in,
    output logic            scl_oe_out,
    input  wire logic       sda_pin_in,
    output logic            sda_oe_out,
    // Drive initialisation context
    input  wire logic       drive_is_atapi_in,
    input  wire logic       drive_pm_supported_in,
    input  wire logic       power_up_reset_in,
    input  wire logic       drive_init_in,
    input  wire logic [7:0] cmd_byte0_in,
    input  wire logic       drq_len_mismatch_in,
    // Decoded configuration
    output logic            load_busy_out,
    output logic            cfg_valid_out,
    output logic            nack_error_out,
    output logic [7:0]      power_mgmt_level_out,
    output logic            issue_power_mgmt_out,
    output logic            vendor_cmd_match_out,
    output logic            mode_page8_out,
    output logic            poll_instead_of_interrupt_out,
    output logic            busy_delay_active_out,
    output logic            short_packet_before_stall_out,
    output logic            drive_soft_reset_out,
    output logic            drive_hard_reset_pin_out
);
    import cfg_loader_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sda_sync;
    logic [2:0] scl_sync;
    logic       sda_s;
    logic       scl_s;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sda_sync <= 3'h7;
            scl_sync <= 3'h7;
            sda_s    <= 1'b1;
            scl_s    <= 1'b1;
        end else begin
            sda_sync <= {sda_sync[1:0], sda_pin_in};
            scl_sync <= {scl_sync[1:0], scl_pin_in};
            if (sda_sync[1] == sda_sync[2]) begin
                sda_s <= sda_sync[2];
            end
            if (scl_sync[1] == scl_sync[2]) begin
                scl_s <= scl_sync[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Bit sequencer: start, write dev, addr 0, restart, read 6, stop
    // ----------------------------------------------------------------
    // Script steps: each step is one serial bit time of four quarters
    localparam int STEPS = 1 + 9 + 9 + 1 + 9 + CFG_BYTES * 9 + 1;
    load_state_t state;
    logic [15:0] quarter_cnt;
    logic [1:0]  phase;
    logic [6:0]  step;
    logic [7:0]  shift;
    logic [2:0]  byte_idx;
    logic [7:0]  cfg_mem [CFG_BYTES];
    logic        nack;
    logic [6:0]  dev_addr;
    logic [7:0]  tx_byte;
    logic [3:0]  bit_pos;
    logic [6:0]  rd_base;
    logic        scl_hi;
    logic        sda_drive_low;
    logic        is_ack_slot;
    logic        is_read_bit;

    assign dev_addr = alt_addr_in ? DEV_ADDR_B : DEV_ADDR_A;
    assign rd_base  = 7'd20 + 7'd9;

    always_comb begin
        scl_hi        = (phase == 2'd1) || (phase == 2'd2);
        sda_drive_low = 1'b0;
        is_ack_slot   = 1'b0;
        is_read_bit   = 1'b0;
        tx_byte       = 8'h00;
        bit_pos       = 4'd0;
        if (step == 7'd0 || step == 7'd19) begin
            // Start or repeated start: SDA falls while SCL high
            sda_drive_low = (phase == 2'd2) || (phase == 2'd3);
            scl_hi        = (phase != 2'd3);
        end else if (step == 7'(STEPS - 1)) begin
            // Stop: SDA rises while SCL high
            sda_drive_low = (phase == 2'd0) || (phase == 2'd1);
            scl_hi        = (phase != 2'd0);
        end else if (step < 7'd29) begin
            if (step < 7'd10) begin
                tx_byte = {dev_addr, 1'b0};
                bit_pos = 4'(step - 7'd1);
            end else if (step < 7'd19) begin
                tx_byte = SIG_LOW_ADDR;
                bit_pos = 4'(step - 7'd10);
            end else begin
                tx_byte = {dev_addr, 1'b1};
                bit_pos = 4'(step - 7'd20);
            end
            if (bit_pos == 4'd8) begin
                is_ack_slot = 1'b1;
            end else begin
                sda_drive_low = !tx_byte[3'(7 - bit_pos)];
            end
        end else begin
            bit_pos = 4'((step - rd_base) % 7'd9);
            if (bit_pos == 4'd8) begin
                // Master acks all but the last byte
                sda_drive_low = (byte_idx != 3'(CFG_BYTES - 1));
            end else begin
                is_read_bit = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state       <= ST_IDLE;
            quarter_cnt <= 16'h0000;
            phase       <= 2'd0;
            step        <= 7'd0;
            shift       <= 8'h00;
            byte_idx    <= 3'd0;
            nack        <= 1'b0;
            scl_oe_out  <= 1'b0;
            sda_oe_out  <= 1'b0;
            for (int i = 0; i < CFG_BYTES; i++) begin
                cfg_mem[i] <= 8'h00;
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    scl_oe_out <= 1'b0;
                    sda_oe_out <= 1'b0;
                    if (load_start_in) begin
                        state       <= ST_RUN;
                        step        <= 7'd0;
                        phase       <= 2'd0;
                        quarter_cnt <= 16'h0000;
                        byte_idx    <= 3'd0;
                        nack        <= 1'b0;
                    end
                end
                ST_RUN: begin
                    scl_oe_out <= !scl_hi;
                    sda_oe_out <= sda_drive_low;
                    // Wait while the EEPROM stretches the clock
                    if (scl_hi && !scl_s && quarter_cnt == 16'h0000) begin
                        quarter_cnt <= 16'h0000;
                    end else if (quarter_cnt == 16'(QUARTER_CYCLES - 1)) begin
                        quarter_cnt <= 16'h0000;
                        phase       <= phase + 2'd1;
                        if (phase == 2'd2 && is_ack_slot && sda_s) begin
                            nack <= 1'b1;
                        end
                        if (phase == 2'd2 && is_read_bit) begin
                            shift <= {shift[6:0], sda_s};
                        end
                        if (phase == 2'd3) begin
                            if (bit_pos == 4'd8 && step >= rd_base) begin
                                cfg_mem[byte_idx] <= shift;
                                byte_idx          <= byte_idx + 3'd1;
                            end
                            if (step == 7'(STEPS - 1)) begin
                                state <= ST_DONE;
                            end else begin
                                step <= step + 7'd1;
                            end
                        end
                    end else begin
                        quarter_cnt <= quarter_cnt + 16'h0001;
                    end
                end
                ST_DONE: begin
                    scl_oe_out <= 1'b0;
                    sda_oe_out <= 1'b0;
                    if (load_start_in) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Validation and decoded settings
    // ----------------------------------------------------------------
    logic sig_ok;
    assign sig_ok = (cfg_mem[0] == SIG_LOW_VALUE) && (cfg_mem[1] == SIG_HIGH_VALUE);

    logic [7:0] power_mgmt;
    logic [7:0] vendor_cmd;
    logic [7:0] options;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            power_mgmt     <= POWER_MGMT_RESET;
            vendor_cmd     <= VENDOR_CMD_RESET;
            options        <= OPTION_RESET;
            cfg_valid_out  <= 1'b0;
            nack_error_out <= 1'b0;
        end else if (state == ST_RUN && step == 7'(STEPS - 1) && phase == 2'd3
                     && quarter_cnt == 16'(QUARTER_CYCLES - 1)) begin
            nack_error_out <= nack;
            if (sig_ok && !nack) begin
                power_mgmt    <= cfg_mem[2];
                vendor_cmd    <= cfg_mem[4];
                options       <= cfg_mem[5];
                cfg_valid_out <= 1'b1;
            end else begin
                power_mgmt    <= POWER_MGMT_RESET;
                vendor_cmd    <= VENDOR_CMD_RESET;
                options       <= OPTION_RESET;
                cfg_valid_out <= 1'b0;
            end
        end
    end

    // Busy delay counter while data lengths disagree
    logic [31:0] delay_cnt;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            delay_cnt <= 32'h0;
        end else if (options[OPT_BUSY_DELAY] && drq_len_mismatch_in) begin
            if (delay_cnt != 32'(BUSY_DELAY_CYCLES)) begin
                delay_cnt <= delay_cnt + 32'h1;
            end
        end else begin
            delay_cnt <= 32'h0;
        end
    end

    assign load_busy_out                 = (state == ST_RUN);
    assign power_mgmt_level_out          = power_mgmt;
    assign issue_power_mgmt_out          = drive_init_in && !drive_is_atapi_in
                                           && drive_pm_supported_in
                                           && (power_mgmt != 8'h00);
    assign vendor_cmd_match_out          = (cmd_byte0_in == vendor_cmd);
    assign mode_page8_out                = options[OPT_MODE_PAGE];
    assign poll_instead_of_interrupt_out = options[OPT_POLL];
    assign busy_delay_active_out         = options[OPT_BUSY_DELAY] && drq_len_mismatch_in
                                           && (delay_cnt != 32'(BUSY_DELAY_CYCLES));
    assign short_packet_before_stall_out = options[OPT_SHORT_PKT];
    assign drive_soft_reset_out          = drive_init_in && options[OPT_SOFT_RESET];
    assign drive_hard_reset_pin_out      = power_up_reset_in
                                           || (drive_init_in && !options[OPT_SKIP_PIN]);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    pm_atapi_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        drive_is_atapi_in |-> !issue_power_mgmt_out)
        else $error("power management issued to ATAPI drive");
    pm_zero_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (power_mgmt_level_out == 8'h00) |-> !issue_power_mgmt_out)
        else $error("power management issued with zero level");
    pm_issue_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (drive_init_in && !drive_is_atapi_in && drive_pm_supported_in
         && power_mgmt_level_out != 8'h00) |-> issue_power_mgmt_out)
        else $error("power management not issued");
    sig_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(cfg_valid_out) |-> $past(cfg_mem[0]) == SIG_LOW_VALUE)
        else $error("config accepted with bad first signature");
    sig_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(cfg_valid_out) |-> $past(cfg_mem[1]) == SIG_HIGH_VALUE)
        else $error("config accepted with bad second signature");
    default_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !cfg_valid_out |-> (options == OPTION_RESET && vendor_cmd == VENDOR_CMD_RESET))
        else $error("defaults not kept without valid signature");
    vendor_match_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!load_busy_out && cmd_byte0_in == (cfg_valid_out ? cfg_mem[4] : VENDOR_CMD_RESET))
        |-> vendor_cmd_match_out)
        else $error("vendor command match wrong");
    hard_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (drive_init_in && options[OPT_SKIP_PIN] && !power_up_reset_in)
        |-> !drive_hard_reset_pin_out)
        else $error("hard reset pin asserted while skipped");
    busy_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        busy_delay_active_out |-> delay_cnt < 32'(BUSY_DELAY_CYCLES))
        else $error("busy delay exceeded its bound");
    poll_opt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $changed(poll_instead_of_interrupt_out) |-> $past(load_busy_out))
        else $error("poll select changed outside a load");

    load_done_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(cfg_valid_out));
    load_bad_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(load_busy_out) && !cfg_valid_out);
    pm_issue_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        issue_power_mgmt_out);
endmodule

/* File: verification/cfg_eeprom_model.sv */
// Behavioural serial configuration EEPROM for the loader bench
module cfg_eeprom_model #(
    parameter logic [6:0] DEV_ADDR = 7'h52
) (
    // Serial pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             scl_oe_out,
    output logic             sda_oe_out,
    // Behaviour control
    input  wire logic        present_in,
    input  wire logic [15:0] stretch_ns_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:255];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh  = 8'h00;
    int         bitc = 0;
    int         phase = 0;
    logic       sel = 1'b0;
    logic       rd = 1'b0;
    logic       sack = 1'b0;
    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
    end
    // ------------------------------------------
    // Start condition
    // ------------------------------------------
    always @(negedge sda_in) begin
        if (scl_in) begin
            bitc = 0;
            phase = 0;
            rd = 1'b0;
            sel = 1'b0;
            sack = 1'b0;
        end
    end
    // ------------------------------------------
    // Bit sampling and master acknowledge
    // ------------------------------------------
    always @(posedge scl_in) begin
        if (bitc < 8) begin
            sh = {sh[6:0], sda_in};
            bitc++;
        end else begin
            if (!sack && rd && sda_in) begin
                sel = 1'b0;
            end
            sack = 1'b0;
            bitc = 0;
        end
    end
    // ------------------------------------------
    // Data out, acknowledge and stretching
    // ------------------------------------------
    always @(negedge scl_in) begin
        if (bitc == 8 && rd) begin
            sda_oe_out = 1'b0;
            ptr++;
        end else if (bitc == 8) begin
            if (phase == 0) begin
                sel = present_in && (sh[7:1] == DEV_ADDR);
                rd = sel && sh[0];
            end else if (phase == 1 && sel) begin
                ptr = sh;
            end
            phase++;
            sack = sel;
            sda_oe_out = sel;
            if (sel && stretch_ns_in != 16'h0000) begin
                scl_oe_out = 1'b1;
                #(stretch_ns_in);
                scl_oe_out = 1'b0;
            end
        end else begin
            sda_oe_out = sel && rd && !mem[ptr][7 - bitc];
        end
    end
endmodule

/* File: verification/test_eeprom_config_loader.sv */
// Self-checking bench for the configuration loader
module test_eeprom_config_loader;
    timeunit 1ns;
    timeprecision 100ps;
    import cfg_loader_pkg::*;
    localparam int BUSY_CYC = 20;
    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       start = 1'b0;
    logic       alt = 1'b0;
    logic       atapi = 1'b0;
    logic       pm = 1'b0;
    logic       pwr = 1'b0;
    logic       init = 1'b0;
    logic       mism = 1'b0;
    logic       present_b = 1'b1;
    logic [7:0] cmd = 8'h00;
    logic       scl_oe, sda_oe, scl_oe_a, sda_oe_a, scl_oe_b, sda_oe_b;
    logic       busy, valid, nack, iss, vmatch, page8, poll, bdly, spkt, drive_soft_reset, hpin;
    logic [7:0] lvl;
    int         bad_count = 0;
    int         compares = 0;
    wire        scl_w;
    wire        sda_w;
    assign scl_w = !(scl_oe | scl_oe_a | scl_oe_b);
    assign sda_w = !(sda_oe | sda_oe_a | sda_oe_b);
    always #12.5 clk_in = ~clk_in;
    // ------------------------------------------
    // Design and EEPROM models
    // ------------------------------------------
    eeprom_config_loader #(.BUSY_DELAY_CYCLES(BUSY_CYC), .QUARTER_CYCLES(2)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .load_start_in(start), .alt_addr_in(alt),
        .scl_pin_in(scl_w), .scl_oe_out(scl_oe), .sda_pin_in(sda_w), .sda_oe_out(sda_oe),
        .drive_is_atapi_in(atapi), .drive_pm_supported_in(pm), .power_up_reset_in(pwr),
        .drive_init_in(init), .cmd_byte0_in(cmd), .drq_len_mismatch_in(mism),
        .load_busy_out(busy), .cfg_valid_out(valid), .nack_error_out(nack),
        .power_mgmt_level_out(lvl), .issue_power_mgmt_out(iss), .vendor_cmd_match_out(vmatch),
        .mode_page8_out(page8), .poll_instead_of_interrupt_out(poll),
        .busy_delay_active_out(bdly), .short_packet_before_stall_out(spkt),
        .drive_soft_reset_out(drive_soft_reset), .drive_hard_reset_pin_out(hpin));
    cfg_eeprom_model #(.DEV_ADDR(DEV_ADDR_A)) ee_a (.scl_in(scl_w), .sda_in(sda_w),
        .scl_oe_out(scl_oe_a), .sda_oe_out(sda_oe_a), .present_in(1'b1),
        .stretch_ns_in(16'h0000));
    cfg_eeprom_model #(.DEV_ADDR(DEV_ADDR_B)) ee_b (.scl_in(scl_w), .sda_in(sda_w),
        .scl_oe_out(scl_oe_b), .sda_oe_out(sda_oe_b), .present_in(present_b),
        .stretch_ns_in(16'h012c));
    // ------------------------------------------
    // Tasks
    // ------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic set_mem(input logic b, input logic [47:0] d);
        for (int i = 0; i < CFG_BYTES; i++) begin
            if (b) begin
                ee_b.mem[i] = d[47 - 8 * i -: 8];
            end else begin
                ee_a.mem[i] = d[47 - 8 * i -: 8];
            end
        end
    endtask
    task automatic load(input logic sel_alt);
        int n;
        n = 0;
        alt = sel_alt;
        start = 1'b1;
        tick(3);
        start = 1'b0;
        check(busy, 1'b1, "busy");
        while (busy !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
        check(busy, 1'b0, "load done");
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(1);
    endtask
    task automatic check_cfg(input logic v, input logic [7:0] l, input logic [7:0] c,
                             input logic [7:0] o);
        cmd = c;
        init = 1'b1;
        atapi = 1'b0;
        pm = 1'b1;
        pwr = 1'b0;
        tick(1);
        check(valid, v, "valid");
        check(lvl, l, "level");
        check(vmatch, 1'b1, "vendor match");
        check(page8, o[5], "page8");
        check(poll, o[4], "poll");
        check(spkt, o[2], "short packet");
        check(drive_soft_reset, o[1], "soft reset");
        check(hpin, !o[0], "hard pin");
        check(iss, l != 8'h00, "issue pm");
        cmd = c ^ 8'h80;
        atapi = 1'b1;
        tick(1);
        check(vmatch, 1'b0, "vendor miss");
        check(iss, 1'b0, "atapi pm");
        atapi = 1'b0;
        pm = 1'b0;
        pwr = 1'b1;
        mism = 1'b1;
        tick(2);
        check(iss, 1'b0, "no pm support");
        check(hpin, 1'b1, "power-up pin");
        check(bdly, o[3], "busy delay");
        init = 1'b0;
        pwr = 1'b0;
        tick(BUSY_CYC - 3);
        check(bdly, o[3], "delay last cycle");
        tick(1);
        check(bdly, 1'b0, "delay ends");
        check(drive_soft_reset, 1'b0, "soft reset idle");
        check(hpin, 1'b0, "pin idle");
        mism = 1'b0;
    endtask
    // ------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------
    initial begin
        repeat (30000) @(posedge clk_in);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        tick(2);
        rst_n_in = 1'b1;
        tick(1);
        check(busy, 1'b0, "idle");
        check_cfg(1'b0, POWER_MGMT_RESET, VENDOR_CMD_RESET, OPTION_RESET);
        set_mem(1'b0, 48'h534b_8000_993a);
        set_mem(1'b1, 48'h534b_0000_5a17);
        load(1'b0);
        check(nack, 1'b0, "addr a");
        check_cfg(1'b1, 8'h80, 8'h99, 8'h3a);
        load(1'b1);
        check(nack, 1'b0, "addr b");
        check_cfg(1'b1, 8'h00, 8'h5a, 8'h17);
        for (int k = 0; k < 3; k++) begin
            set_mem(1'b0, 48'h534b_8000_993a);
            load(1'b0);
            check(valid, 1'b1, "reload");
            if (k < 2) begin
                ee_a.mem[k] = ee_a.mem[k] ^ 8'h10;
            end
            present_b = (k < 2);
            load(k == 2);
            check(nack, k == 2, "nack");
            check_cfg(1'b0, POWER_MGMT_RESET, VENDOR_CMD_RESET, OPTION_RESET);
        end
        // Reset in the middle of a load, while the word address is sent
        alt = 1'b0;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(200);
        rst_n_in = 1'b0;
        tick(2);
        rst_n_in = 1'b1;
        tick(1);
        check(busy, 1'b0, "reset idle");
        check_cfg(1'b0, POWER_MGMT_RESET, VENDOR_CMD_RESET, OPTION_RESET);
        load(1'b0);
        check(nack, 1'b0, "addr a again");
        check_cfg(1'b1, 8'h80, 8'h99, 8'h3a);
        tally_and_finish();
    end
endmodule
